/* File: core/ic_cache.sv */
// 4 KB direct-mapped instruction cache with line-fill buffer
//
// Our own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module ic_cache
    import ic_pkg::*;
(
    // clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    // register bus
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        bdm_mode,
    // fetch port, core or debug module
    input  wire logic        f_req,
    input  wire logic [31:0] f_addr,
    input  wire logic        f_sram,
    output logic             f_ready,
    output logic             f_rvalid,
    output logic [31:0]      f_rdata,
    output ic_attr_t         f_attr,
    // single line invalidate
    input  wire logic        linv_req,
    input  wire logic [31:0] linv_addr,
    // external bus controller
    output ic_ext_t          ext,
    input  wire logic        ext_ack,
    input  wire logic [31:0] ext_rdata,
    // status
    output logic             inv_busy
);
    ic_state_t s;
    ic_state_t next_s;

    logic [IC_TAG_W-1:0] tag_mem [IC_LINES];
    logic                vld_mem [IC_LINES];
    logic [31:0]         data_mem [IC_WORDS];

    logic          en;
    logic          arr_hit;
    logic          fb_line;
    logic          fb_hit;
    logic          hit;
    logic          miss;
    logic          accept;
    logic          m0;
    logic          m1;
    ic_attr_t      a0;
    ic_attr_t      a1;
    ic_attr_t      eff;
    logic          line_sz;
    logic          flush;
    logic          inv_start;
    logic [31:0]   arr_data;
    logic [31:0]   fb_word;
    logic          ctl_nc;
    logic [3:0]    beat_mask;

    assign en = s.ctrl[IC_B_ENABLE];

    // both arrays read in parallel from the fetch address
    assign arr_data = data_mem[f_addr[11:2]];
    assign arr_hit  = en && vld_mem[f_addr[11:4]] &&
                      (tag_mem[f_addr[11:4]] == f_addr[31:12]);
    assign fb_line  = en && (s.fb_addr == f_addr[31:4]);
    assign fb_hit   = fb_line && s.fb_vld[f_addr[3:2]];
    assign fb_word  = s.fb_data[32*f_addr[3:2] +: 32];
    assign hit      = arr_hit || fb_hit;
    assign miss     = !hit && !f_sram;

    ic_region_match u_rgn0 (
        .addr  (f_addr),
        .rgn   (s.rgn0),
        .match (m0),
        .attr  (a0)
    );
    ic_region_match u_rgn1 (
        .addr  (f_addr),
        .rgn   (s.rgn1),
        .match (m1),
        .attr  (a1)
    );

    // region zero wins when both match
    always_comb begin
        if (m0) begin
            eff = a0;
        end else if (m1) begin
            eff = a1;
        end else begin
            eff = '{noncache: s.ctrl[IC_B_DEFNC],
                    buffered: s.ctrl[IC_B_DEFBUF],
                    wprot:    s.ctrl[IC_B_DEFWP]};
        end
    end

    // line unless the table asks for a single longword
    always_comb begin
        case (s.ctrl[IC_LNF_MSB:IC_LNF_LSB])
            2'b00:   line_sz = (f_addr[3:2] != 2'b11);
            2'b01:   line_sz = !f_addr[3];
            default: line_sz = 1'b1;
        endcase
    end

    // while the rest of a line streams in, only hits and SRAM fetches are taken; a miss
    // waits, since the buffer holds only one line
    always_comb begin
        if (s.inv_busy || inv_start) begin
            f_ready = 1'b0;
        end else begin
            case (s.fs)
                IC_FS_IDLE: f_ready = 1'b1;
                IC_FS_REST: f_ready = f_sram || hit;
                default:    f_ready = 1'b0;
            endcase
        end
    end

    assign accept    = f_req && f_ready;
    assign inv_start = s.ap_valid && s.ap_write &&
                       (s.ap_addr == IC_OFF_CTRL) && hwdata[IC_B_INVALL];
    // frozen cache never overwrites a valid line
    assign flush     = accept && miss && s.mru && !s.fb_nc &&
                       (s.fb_vld == 4'hF) && !s.inv_busy && !inv_start &&
                       !(s.ctrl[IC_B_FREEZE] && vld_mem[s.fb_addr[7:0]]);
    assign ctl_nc    = s.ctrl[IC_B_NCBURST];
    assign beat_mask = 4'h1 << s.wptr;

    always_comb begin
        next_s        = s;
        next_s.rvalid = 1'b0;
        next_s.ap_valid = hsel && htrans[1] && hready;
        next_s.ap_write = hwrite;
        next_s.ap_addr  = haddr[7:0];

        // register writes in the data phase
        if (s.ap_valid && s.ap_write) begin
            case (s.ap_addr)
                IC_OFF_CTRL: begin
                    next_s.ctrl = hwdata;
                    next_s.ctrl[IC_B_INVALL] = 1'b0;
                end
                IC_OFF_RGN0: next_s.rgn0 = hwdata;
                IC_OFF_RGN1: next_s.rgn1 = hwdata;
                default:     next_s.ctrl = s.ctrl;
            endcase
        end

        // full invalidation, one tag per cycle
        if (s.inv_busy) begin
            next_s.inv_cnt = s.inv_cnt + 8'h01;
            if (s.inv_cnt == 8'(IC_INV_CYCLES - 1)) begin
                next_s.inv_busy = 1'b0;
            end
        end
        if (inv_start) begin
            next_s.inv_busy = 1'b1;
            next_s.inv_cnt  = 8'h00;
            next_s.mru      = 1'b0;
        end

        // returning beats of an external fetch
        if (s.fs != IC_FS_IDLE && ext_ack) begin
            if (s.use_fb) begin
                next_s.fb_data[32*s.wptr +: 32] = ext_rdata;
                next_s.fb_vld = s.fb_vld | beat_mask;
            end
            next_s.wptr  = s.wptr + 2'b01;
            next_s.beats = s.beats - 3'd1;
            if (s.fs == IC_FS_CRIT) begin
                next_s.rvalid = 1'b1;
                next_s.rdata  = ext_rdata;
            end
            if (s.beats == 3'd1) begin
                next_s.fs      = IC_FS_IDLE;
                next_s.ext.req = 1'b0;
            end else begin
                next_s.fs = IC_FS_REST;
            end
        end

        // accepted fetch; debug fetches take the same path
        if (accept && !f_sram) begin
            next_s.attr = eff;
            if (hit) begin
                next_s.rvalid = 1'b1;
                next_s.rdata  = fb_hit ? fb_word : arr_data;
                if (!fb_hit && (f_addr[8:4] == s.fb_addr[4:0])) begin
                    next_s.mru = 1'b0;
                end
            end else begin
                next_s.fs      = IC_FS_CRIT;
                next_s.ext.req = 1'b1;
                next_s.wptr    = f_addr[3:2];
                if (!en) begin
                    // odd word address gives a word fetch
                    next_s.use_fb   = 1'b0;
                    next_s.beats    = 3'd1;
                    next_s.ext.addr = {f_addr[31:1], 1'b0};
                    next_s.ext.size = f_addr[1] ? IC_SZ_WORD : IC_SZ_LONG;
                end else if (eff.noncache && !ctl_nc) begin
                    next_s.use_fb   = 1'b0;
                    next_s.beats    = 3'd1;
                    next_s.ext.addr = {f_addr[31:2], 2'b00};
                    next_s.ext.size = IC_SZ_LONG;
                end else begin
                    next_s.use_fb   = 1'b1;
                    next_s.fb_nc    = eff.noncache;
                    next_s.fb_addr  = f_addr[31:4];
                    next_s.fb_vld   = 4'h0;
                    next_s.mru      = !inv_start;
                    next_s.beats    = line_sz ? 3'd4 : 3'd1;
                    next_s.ext.addr = {f_addr[31:2], 2'b00};
                    next_s.ext.size = line_sz ? IC_SZ_LINE : IC_SZ_LONG;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s          <= '0;
            s.ctrl     <= IC_CTRL_RST;
            s.rgn0     <= IC_RGN_RST;
            s.rgn1     <= IC_RGN_RST;
            s.fs       <= IC_FS_IDLE;
            s.ext.size <= IC_SZ_NONE;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    // arrays carry no reset: tag contents survive a hardware reset
    always_ff @(posedge sys_clk) begin
        if (clk_en) begin
            if (flush) begin
                tag_mem[s.fb_addr[7:0]] <= s.fb_addr[27:8];
                vld_mem[s.fb_addr[7:0]] <= 1'b1;
                for (int w = 0; w < 4; w++) begin
                    data_mem[{s.fb_addr[7:0], 2'(w)}] <=
                        s.fb_data[32*w +: 32];
                end
            end
            // data writes are not watched; only explicit invalidates clear
            if (linv_req && !s.ctrl[IC_B_NOINVL]) begin
                vld_mem[linv_addr[11:4]] <= 1'b0;
            end
            if (s.inv_busy) begin
                vld_mem[s.inv_cnt] <= 1'b0;
            end
        end
    end

    // zero wait states; control and regions read back only in debug
    always_comb begin
        hrdata = 32'h00000000;
        if (s.ap_valid && !s.ap_write) begin
            case (s.ap_addr)
                IC_OFF_CTRL: hrdata = bdm_mode ? s.ctrl : 32'h00000000;
                IC_OFF_RGN0: hrdata = bdm_mode ? s.rgn0 : 32'h00000000;
                IC_OFF_RGN1: hrdata = bdm_mode ? s.rgn1 : 32'h00000000;
                IC_OFF_STAT: hrdata = {22'h000000, s.fb_nc, s.mru,
                                       s.fb_vld, s.fs, s.inv_busy,
                                       s.use_fb};
                default:     hrdata = 32'h00000000;
            endcase
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign f_rvalid  = s.rvalid;
    assign f_rdata   = s.rdata;
    assign f_attr    = s.attr;
    assign ext       = s.ext;
    assign inv_busy  = s.inv_busy;
endmodule
`default_nettype wire

/* File: core/ic_pkg.sv */
// shared constants, types and register map of the instruction cache
package ic_pkg;

    // geometry
    localparam int IC_LINES       = 256;
    localparam int IC_WORDS       = 1024;
    localparam int IC_TAG_W       = 20;
    localparam int IC_INV_CYCLES  = 256;

    // register byte offsets on the bus
    localparam logic [7:0] IC_OFF_CTRL = 8'h00;
    localparam logic [7:0] IC_OFF_RGN0 = 8'h04;
    localparam logic [7:0] IC_OFF_RGN1 = 8'h08;
    localparam logic [7:0] IC_OFF_STAT = 8'h0C;

    // reset values
    localparam logic [31:0] IC_CTRL_RST = 32'h00000000;
    localparam logic [31:0] IC_RGN_RST  = 32'h00000000;

    // cache_control_reg bit positions
    localparam int IC_B_ENABLE  = 31;
    localparam int IC_B_NOINVL  = 28;
    localparam int IC_B_FREEZE  = 27;
    localparam int IC_B_INVALL  = 24;
    localparam int IC_B_NCBURST = 10;
    localparam int IC_B_DEFNC   = 9;
    localparam int IC_B_DEFBUF  = 8;
    localparam int IC_B_DEFWP   = 5;
    localparam int IC_LNF_MSB   = 1;
    localparam int IC_LNF_LSB   = 0;

    // region register field positions
    localparam int IC_R_BASE_MSB = 31;
    localparam int IC_R_BASE_LSB = 24;
    localparam int IC_R_MASK_MSB = 23;
    localparam int IC_R_MASK_LSB = 16;
    localparam int IC_R_EN       = 15;
    localparam int IC_R_NC       = 6;
    localparam int IC_R_BUF      = 5;
    localparam int IC_R_WP       = 2;

    typedef enum logic [1:0] {
        IC_FS_IDLE = 2'b00,
        IC_FS_CRIT = 2'b01,
        IC_FS_REST = 2'b10
    } ic_fs_t;

    typedef enum logic [1:0] {
        IC_SZ_NONE = 2'b00,
        IC_SZ_WORD = 2'b01,
        IC_SZ_LONG = 2'b10,
        IC_SZ_LINE = 2'b11
    } ic_size_t;

    typedef struct packed {
        logic noncache;
        logic buffered;
        logic wprot;
    } ic_attr_t;

    typedef struct packed {
        logic        req;
        logic [31:0] addr;
        ic_size_t    size;
    } ic_ext_t;

    typedef struct packed {
        logic [31:0]  ctrl;
        logic [31:0]  rgn0;
        logic [31:0]  rgn1;
        logic         inv_busy;
        logic [7:0]   inv_cnt;
        ic_fs_t       fs;
        ic_ext_t      ext;
        logic [2:0]   beats;
        logic [1:0]   wptr;
        logic         use_fb;
        logic [27:0]  fb_addr;
        logic [3:0]   fb_vld;
        logic [127:0] fb_data;
        logic         fb_nc;
        logic         mru;
        logic         rvalid;
        logic [31:0]  rdata;
        ic_attr_t     attr;
        logic         ap_write;
        logic         ap_valid;
        logic [7:0]   ap_addr;
    } ic_state_t;

endpackage

/* File: core/ic_region_match.sv */
// base and mask address comparator for one region attribute register
`timescale 1ns/1ps
`default_nettype none
module ic_region_match
    import ic_pkg::*;
(
    // address and region setting
    input  wire logic [31:0] addr,
    input  wire logic [31:0] rgn,
    // result
    output logic             match,
    output ic_attr_t         attr
);
    logic [7:0] base;
    logic [7:0] mask;

    // mask bits set mean "ignore this address bit"
    assign base  = rgn[IC_R_BASE_MSB:IC_R_BASE_LSB];
    assign mask  = rgn[IC_R_MASK_MSB:IC_R_MASK_LSB];
    assign match = rgn[IC_R_EN] &&
                   (((addr[31:24] ^ base) & ~mask) == 8'h00);
    assign attr  = '{noncache: rgn[IC_R_NC],
                     buffered: rgn[IC_R_BUF],
                     wprot:    rgn[IC_R_WP]};
endmodule
`default_nettype wire

/* File: verification/ic_cache_asserts.sv */
// port checker for the instruction cache
`timescale 1ns/1ps
`default_nettype none
module ic_cache_asserts
    import ic_pkg::*;
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        clk_en,
    // register bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    // fetch and external side
    input wire logic        f_req,
    input wire logic [31:0] f_addr,
    input wire logic        f_sram,
    input wire logic        f_ready,
    input wire logic        f_rvalid,
    input wire ic_attr_t    f_attr,
    input wire ic_ext_t     ext,
    input wire logic        ext_ack,
    input wire logic        inv_busy
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    logic        wr_ph;
    logic [31:0] ctl;
    logic [31:0] acc;
    logic [1:0]  beat;
    logic [8:0]  inv_n;
    logic        last;
    assign last = ext.req && ext_ack
                  && (beat == 2'b11 || ext.size != IC_SZ_LINE);
    // shadow of the control register, taken from bus writes
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_ph <= 1'b0;
            ctl   <= 32'h0000_0000;
            acc   <= 32'h0000_0000;
            beat  <= 2'b00;
            inv_n <= 9'h000;
        end else if (clk_en) begin
            wr_ph <= hsel && htrans[1] && hready && hwrite
                     && haddr[7:0] == IC_OFF_CTRL;
            ctl   <= wr_ph ? hwdata : ctl;
            acc   <= (f_req && f_ready) ? f_addr : acc;
            beat  <= ext.req ? beat + 2'(ext_ack) : 2'b00;
            inv_n <= inv_busy ? inv_n + 9'h001 : 9'h000;
        end
    end
    property p_inv_start;
        wr_ph && clk_en && hwdata[IC_B_INVALL] |=> inv_busy;
    endproperty
    property p_inv_len;
        $fell(inv_busy) |-> inv_n == 9'h100;
    endproperty
    property p_inv_stall;
        inv_busy |-> !f_ready;
    endproperty
    property p_sram;
        f_req && f_ready && f_sram
            |=> !f_rvalid && ($past(ext.req) || !ext.req);
    endproperty
    property p_crit;
        ext.req && ext_ack && beat == 2'b00 |=> f_rvalid;
    endproperty
    property p_hold;
        ext.req && !last |=> ext.req && $stable(ext.addr);
    endproperty
    property p_last;
        last |=> !ext.req;
    endproperty
    property p_addr;
        $rose(ext.req) |-> ext.addr[31:2] == acc[31:2];
    endproperty
    property p_size;
        $rose(ext.req) && ext.size == IC_SZ_LINE |-> ctl[IC_B_ENABLE]
            && !(ctl[1:0] == 2'b00 && acc[3:2] == 2'b11)
            && !(ctl[1:0] == 2'b01 && acc[3]);
    endproperty
    property p_nc_long;
        $rose(ext.req) && ctl[IC_B_ENABLE] && !ctl[IC_B_NCBURST]
            && f_attr.noncache |-> ext.size == IC_SZ_LONG;
    endproperty
    a_inv_start: assert property (p_inv_start)
        else $error("invalidation did not start");
    a_inv_len: assert property (p_inv_len)
        else $error("invalidation length wrong");
    a_inv_stall: assert property (p_inv_stall)
        else $error("fetch taken during invalidation");
    a_sram: assert property (p_sram)
        else $error("sram fetch answered by cache");
    a_crit: assert property (p_crit)
        else $error("critical word not returned");
    a_hold: assert property (p_hold)
        else $error("external request changed early");
    a_last: assert property (p_last)
        else $error("external request too long");
    a_addr: assert property (p_addr)
        else $error("external address not miss address");
    a_size: assert property (p_size)
        else $error("line fetch where not allowed");
    a_nc_long: assert property (p_nc_long)
        else $error("noncacheable fetch not longword");
    c_inv: cover property ($rose(inv_busy));
    c_line: cover property (last && beat == 2'b11);
    c_sram: cover property (f_req && f_ready && f_sram);
endmodule
bind ic_cache ic_cache_asserts u_chk (.*);
`default_nettype wire

/* File: verification/ic_cache_test.sv */
// self-checking bench for the instruction cache
`timescale 1ns/1ps
`default_nettype none
module ic_cache_test
    import ic_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        bdm_mode = 1'b1;
    logic        clk_en = 1'b1;
    logic        f_req = 1'b0;
    logic [31:0] f_addr = 32'h0000_0000;
    logic        f_sram = 1'b0;
    logic        linv_req = 1'b0;
    logic [31:0] linv_addr = 32'h0000_0000;
    logic [1:0]  wait_n = 2'b00;
    logic        hreadyout, hresp, f_ready, f_rvalid, ext_ack, inv_busy;
    logic [31:0] hrdata, f_rdata, ext_rdata, q;
    ic_attr_t    f_attr;
    ic_ext_t     ext;
    logic        er_q = 1'b0;
    int          fails, cmp_count, n_ext, n_ack, lat, b, e;
    int          seed = 33551;

    ic_cache DUT (.*, .hsize(3'b010), .hready(hreadyout));
    ic_ext_model u_ext (.*);

    initial forever #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        er_q  <= ext.req;
        n_ext <= n_ext + int'(ext.req && !er_q);
        n_ack <= n_ack + int'(ext.req && ext_ack);
    end

    function automatic logic [31:0] mem(input logic [31:0] x);
        return {x[31:2], 2'b00} ^ 32'hC3C3_3C3C;
    endfunction
    function automatic int beats(input int i);
        return (i[3:2] == 0 && i[1:0] == 3 || i[3:2] == 1 && i[1]) ? 1 : 4;
    endfunction
    task automatic chk(input string n, input logic [31:0] s,
                       input logic [31:0] x);
        cmp_count++;
        if (s !== x) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {24'h00_0000, a};
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        q = hrdata;
        chk("hresp", hresp, 0);
    endtask
    // lat is 40 when no data came back
    task automatic fetch(input logic [31:0] a, input logic s);
        f_req  <= 1'b1;
        f_addr <= a;
        f_sram <= s;
        wait_n <= 2'($random(seed));
        @(posedge sys_clk);
        while (f_ready !== 1'b1) @(posedge sys_clk);
        f_req <= 1'b0;
        for (lat = 1; lat < 40; lat++) begin
            @(posedge sys_clk);
            if (f_rvalid === 1'b1) break;
        end
        if (!s) chk("f_rdata", f_rdata, mem(a));
    endtask
    task automatic idle();
        while (ext.req !== 1'b0) @(posedge sys_clk);
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic linv(input logic [31:0] x);
        linv_addr <= x;
        linv_req  <= 1'b1;
        @(posedge sys_clk);
        linv_req  <= 1'b0;
        e = n_ext;
        fetch(x, 0);
    endtask

    initial begin
        #300000;
        fails++;
        close_out();
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        ahb(0, IC_OFF_CTRL, 0);
        chk("ctrl", q, IC_CTRL_RST);
        ahb(1, IC_OFF_RGN1, 32'h4400_8020);
        ahb(0, IC_OFF_RGN1, 0);
        chk("rgn1", q, 32'h4400_8020);
        bdm_mode <= 1'b0;
        ahb(0, IC_OFF_RGN1, 0);
        chk("rgn1 hidden", q, 0);
        bdm_mode <= 1'b1;
        ahb(0, 8'h10, 0);
        chk("unmapped", q, 0);
        e = n_ext;
        repeat (2) fetch(32'h1000_0040, 0);
        chk("off ext", n_ext - e, 2);
        ahb(1, IC_OFF_CTRL, 32'h0100_0000);
        @(posedge sys_clk);
        chk("inv_busy", inv_busy, 1);
        clk_en <= 1'b0;
        repeat (300) @(posedge sys_clk);
        chk("frozen", inv_busy, 1);
        clk_en <= 1'b1;
        while (inv_busy !== 1'b0) @(posedge sys_clk);
        ahb(0, IC_OFF_CTRL, 0);
        chk("inv bit", q[24], 0);
        ahb(1, IC_OFF_CTRL, 32'h8000_0002);
        b = n_ack;
        fetch(32'h1000_0048, 0);
        chk("miss lat", 32'(lat > 1), 1);
        idle();
        chk("line beats", n_ack - b, 4);
        for (int k = 0; k < 16; k += 4) begin
            fetch(32'h1000_0040 + k, 0);
            chk("fb hit", lat, 1);
        end
        e = n_ext;
        fetch(32'h1000_0100, 0);
        ahb(0, IC_OFF_STAT, 0);
        chk("mru", q[8], 1);
        idle();
        fetch(32'h1000_0044, 0);
        chk("array hit", lat, 1);
        chk("array ext", n_ext - e, 1);
        linv(32'h1000_0040);
        chk("linv ext", n_ext - e, 1);
        idle();
        ahb(1, IC_OFF_CTRL, 32'h9000_0002);
        fetch(32'h1000_0200, 0);
        idle();
        linv(32'h1000_0040);
        chk("linv off", n_ext - e, 0);
        for (int i = 0; i < 16; i++) begin
            ahb(1, IC_OFF_CTRL, 32'h8000_0000 | i[3:2]);
            b = n_ack;
            fetch(32'h2000_0000 | (i << 12) | {i[1:0], 2'b00}, 0);
            idle();
            chk("fill beats", n_ack - b, beats(i));
        end
        ahb(1, IC_OFF_RGN0, 32'h3000_8040);
        ahb(1, IC_OFF_CTRL, 32'h8000_0322);
        b = n_ack;
        fetch(32'h5000_0000, 0);
        chk("dflt attr", f_attr, 3'b111);
        fetch(32'h3000_0000, 0);
        chk("rgn attr", f_attr, 3'b100);
        idle();
        chk("nc beats", n_ack - b, 2);
        ahb(1, IC_OFF_CTRL, 32'h8000_0722);
        fetch(32'h3000_0010, 0);
        idle();
        fetch(32'h3000_0014, 0);
        chk("nc fb hit", lat, 1);
        chk("nc burst", n_ack - b, 6);
        e = n_ext;
        fetch(32'h6000_0000, 1);
        chk("sram lat", lat, 40);
        chk("sram ext", n_ext - e, 0);
        ahb(1, IC_OFF_CTRL, 32'h8000_0002);
        repeat (40) fetch(32'h1000_0000 | ($random(seed) & 32'h1FFC), 0);
        close_out();
    end
endmodule
`default_nettype wire

/* File: verification/ic_ext_model.sv */
// external bus controller model answering cache fetches beat by beat
`timescale 1ns/1ps
`default_nettype none
module ic_ext_model
    import ic_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // wait states before each beat
    input  wire logic [1:0]  wait_n,
    // fetch link
    input  wire ic_ext_t     ext,
    output logic             ext_ack,
    output logic [31:0]      ext_rdata
);
    logic [1:0]  beat;
    logic [1:0]  dly;
    logic        done;
    logic [31:0] a;
    assign a = {ext.addr[31:4], ext.addr[3:2] + beat, 2'b00};
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            beat      <= 2'b00;
            dly       <= 2'b00;
            done      <= 1'b0;
            ext_ack   <= 1'b0;
            ext_rdata <= 32'h0000_0000;
        end else begin
            ext_ack   <= 1'b0;
            // no stale word between beats
            ext_rdata <= ~ext_rdata;
            if (!ext.req) begin
                beat <= 2'b00;
                dly  <= wait_n;
                done <= 1'b0;
            end else if (ext_ack) begin
                beat <= beat + 2'b01;
                dly  <= wait_n;
                done <= beat == 2'b11 || ext.size != IC_SZ_LINE;
            end else if (dly != 2'b00) begin
                dly <= dly - 2'b01;
            end else if (!done) begin
                ext_ack   <= 1'b1;
                ext_rdata <= a ^ 32'hC3C3_3C3C;
            end
        end
    end
endmodule
`default_nettype wire
